/* File: include/irq_summary_defines.vh */
// register offsets, bit positions and reset values of the interrupt summary
`ifndef IRQ_SUMMARY_DEFINES_VH
`define IRQ_SUMMARY_DEFINES_VH

// host address width and data width of the byte-wide register port
`define ADDR_W              10
`define DATA_W              8

// byte addresses of the summary status word (read only)
`define STATUS_LO_ADDR      10'h010
`define STATUS_HI_ADDR      10'h011

// byte addresses of the companion interrupt enable word
`define ENABLE_LO_ADDR      10'h012
`define ENABLE_HI_ADDR      10'h013

// byte address of the byte that holds the watchdog expired flag
`define WDT_CTRL_ADDR       10'h0B0

// bit positions inside the 16-bit summary status word
`define BIT_TIMER           14
`define BIT_READY           12
`define BIT_POWER           10
`define BIT_VBUS            9
`define BIT_HOTPLUG         8
`define BIT_PSWITCH         7
`define BIT_WATCHDOG        6
`define BIT_PORTPWR         5
`define BIT_PDLINK          4
`define BIT_OVERCUR         3
`define BIT_PINOVR          2
`define BIT_PINCHG          1
`define BIT_CABLE           0

// implemented bits; 15, 13 and 11 are reserved and read zero
`define STATUS_MASK         16'h57FF

// reset values
`define STATUS_RESET        16'h0000
`define ENABLE_RESET        16'h1040
`define RDATA_RESET         8'h00

`endif

/* File: src/irq_enable_reg.v */
// interrupt enable word with byte-wide writes and per-bit gating
`timescale 1ns/1ps
`include "irq_summary_defines.vh"

module irq_enable_reg
#(
    parameter WIDTH = 16
)
(
    input  wire               clk_sys_in,
    input  wire               nrst_in,
    input  wire               wr_lo_in,
    input  wire               wr_hi_in,
    input  wire [7:0]         wdata_in,
    input  wire [WIDTH-1:0]   status_in,
    output wire [WIDTH-1:0]   enable_out,
    output wire [WIDTH-1:0]   gated_out
);

    reg  [WIDTH-1:0] enable_reg;
    reg  [WIDTH-1:0] enable_next;
    wire [WIDTH-1:0] implemented;

    assign implemented = `STATUS_MASK;

    // merge the written byte lanes, reserved bits stay zero
    always @*
    begin
        enable_next = enable_reg;
        if (wr_lo_in)
        begin
            enable_next[7:0] = wdata_in;
        end
        if (wr_hi_in)
        begin
            enable_next[15:8] = wdata_in;
        end
        enable_next = enable_next & implemented;
    end

    // enable storage with documented reset pattern
    always @(posedge clk_sys_in)
    begin
        if (!nrst_in)
        begin
            enable_reg <= `ENABLE_RESET;
        end
        else
        begin
            enable_reg <= enable_next;
        end
    end

    assign enable_out = enable_reg;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : gate_g
            assign gated_out[i] = status_in[i] & enable_reg[i];
        end
    endgenerate

endmodule // irq_enable_reg

/* File: src/interrupt_summary_status.v */
// top-level interrupt summary status word, enable gating and write lock
`timescale 1ns/1ps
`include "irq_summary_defines.vh"

// Function
// - timer underflow raises status bit 14
// - bit 14 follows timer underflow flag
// - bit 12 set when device ready
// - bit 12 mirrors configured flag one cycle later
// - power event drives bit 10
// - bus voltage change drives bit 9
// - hot-plug interrupt drives bit 8
// - power switch interrupt drives bit 7
// - watchdog expiry drives bit 6
// - watchdog pending blocks writes except clear
// - port power interrupt drives bit 5
// - power delivery link drives bit 4
// - overcurrent change drives bit 3
// - pin override drives bit 2
// - pin change drives bit 1
// - cable detect drives bit 0
// - 16-bit read-only word at 0010h
// - zero enable bit suppresses that interrupt
// - device sets configured flag after setup
module interrupt_summary_status
#(
    parameter VBUS_W = 8,
    parameter OCS_W  = 8,
    parameter PIN_W  = 16
)
(
    input  wire                clk_sys_in,
    input  wire                nrst_in,
    input  wire                timer_underflow_flag_in,
    input  wire                config_done_in,
    input  wire                power_irq_pending_in,
    input  wire [VBUS_W-1:0]   bus_voltage_change_in,
    input  wire                hot_plug_pending_in,
    input  wire                power_switch_pending_in,
    input  wire                watchdog_expired_flag_in,
    input  wire                port_power_pending_in,
    input  wire                pd_link_pending_in,
    input  wire [OCS_W-1:0]    overcurrent_change_in,
    input  wire                pin_override_pending_in,
    input  wire [PIN_W-1:0]    pin_irq_status_in,
    input  wire                cable_detect_pending_in,
    input  wire [`ADDR_W-1:0]  host_addr_in,
    input  wire                host_wr_in,
    input  wire                host_rd_in,
    input  wire [`DATA_W-1:0]  host_wdata_in,
    output wire                host_wr_pass_out,
    output reg  [`DATA_W-1:0]  host_rdata_out,
    output reg                 host_rvalid_out,
    output wire                configured_flag_out,
    output wire [15:0]         interrupt_summary_status_out,
    output wire [15:0]         interrupt_enable_out,
    output wire                irq_n_out
);

    // state
    reg  [15:0]        status_reg;
    reg  [15:0]        status_next;
    reg                configured_flag_reg;
    reg                configured_flag_next;
    reg                irq_reg;
    reg  [`DATA_W-1:0] rdata_next;
    reg                irq_next;
    reg                wr_allowed;
    reg                wr_enable_lo;
    reg                wr_enable_hi;

    // decode and gating wires
    wire               watchdog_pending;
    wire [15:0]        enable_word;
    wire [15:0]        gated_word;
    wire               any_gated;
    wire               vbus_any;
    wire               ocs_any;
    wire               pin_any;
    wire               lock_hit;
    wire               hit_status_lo;
    wire               hit_status_hi;
    wire               hit_enable_lo;
    wire               hit_enable_hi;

    // address compare shared by read and write decode
    function addr_hit;
        input [`ADDR_W-1:0] addr;
        input [`ADDR_W-1:0] target;
        begin
            addr_hit = (addr == target);
        end
    endfunction

    // pick one byte lane of a 16-bit word
    function [7:0] byte_sel;
        input [15:0] word;
        input        upper;
        begin
            if (upper)
            begin
                byte_sel = word[15:8];
            end
            else
            begin
                byte_sel = word[7:0];
            end
        end
    endfunction

    // device sets its own configured flag
    always @*
    begin
        configured_flag_next = configured_flag_reg;
        if (config_done_in)
        begin
            configured_flag_next = 1'b1;
        end
    end

    // configured flag clears only with system reset
    always @(posedge clk_sys_in)
    begin
        if (!nrst_in)
        begin
            configured_flag_reg <= 1'b0;
        end
        else
        begin
            configured_flag_reg <= configured_flag_next;
        end
    end

    assign configured_flag_out = configured_flag_reg;

    // any set bit of a vector source raises its summary bit
    assign vbus_any = |bus_voltage_change_in;
    assign ocs_any  = |overcurrent_change_in;
    assign pin_any  = |pin_irq_status_in;

    // gather the source flags into the summary word
    always @*
    begin
        status_next = `STATUS_RESET;
        status_next[`BIT_TIMER]    = timer_underflow_flag_in;
        status_next[`BIT_READY]    = configured_flag_reg;
        status_next[`BIT_POWER]    = power_irq_pending_in;
        status_next[`BIT_VBUS]     = vbus_any;
        status_next[`BIT_HOTPLUG]  = hot_plug_pending_in;
        status_next[`BIT_PSWITCH]  = power_switch_pending_in;
        status_next[`BIT_WATCHDOG] = watchdog_expired_flag_in;
        status_next[`BIT_PORTPWR]  = port_power_pending_in;
        status_next[`BIT_PDLINK]   = pd_link_pending_in;
        status_next[`BIT_OVERCUR]  = ocs_any;
        status_next[`BIT_PINOVR]   = pin_override_pending_in;
        status_next[`BIT_PINCHG]   = pin_any;
        status_next[`BIT_CABLE]    = cable_detect_pending_in;
        status_next = status_next & `STATUS_MASK;
    end

    // status reloads every cycle, host writes never reach it
    always @(posedge clk_sys_in)
    begin
        if (!nrst_in)
        begin
            status_reg <= `STATUS_RESET;
        end
        else
        begin
            status_reg <= status_next;
        end
    end

    // read-only word presented to the rest of the device
    assign interrupt_summary_status_out = status_reg;

    // watchdog interrupt pending as seen in the summary word
    assign watchdog_pending = status_reg[`BIT_WATCHDOG];

    // the watchdog control byte stays writable to lift the lock
    assign lock_hit = addr_hit(host_addr_in, `WDT_CTRL_ADDR);

    // block writes while watchdog pending, except its clear
    always @*
    begin
        wr_allowed = 1'b0;
        if (host_wr_in)
        begin
            if (!watchdog_pending)
            begin
                wr_allowed = 1'b1;
            end
            else if (lock_hit)
            begin
                wr_allowed = 1'b1;
            end
        end
    end

    // gated write strobe for every other register of the device
    assign host_wr_pass_out = wr_allowed;

    // byte address hits for read decode; the enable hits serve write decode too
    assign hit_status_lo = addr_hit(host_addr_in, `STATUS_LO_ADDR);
    assign hit_status_hi = addr_hit(host_addr_in, `STATUS_HI_ADDR);
    assign hit_enable_lo = addr_hit(host_addr_in, `ENABLE_LO_ADDR);
    assign hit_enable_hi = addr_hit(host_addr_in, `ENABLE_HI_ADDR);

    // enable word byte lanes, subject to the same write lock
    always @*
    begin
        wr_enable_lo = 1'b0;
        wr_enable_hi = 1'b0;
        if (wr_allowed)
        begin
            if (hit_enable_lo)
            begin
                wr_enable_lo = 1'b1;
            end
            else if (hit_enable_hi)
            begin
                wr_enable_hi = 1'b1;
            end
        end
    end

    // enable register and per-bit gating
    irq_enable_reg
    #(
        .WIDTH      (16)
    )
    u_enable
    (
        .clk_sys_in (clk_sys_in),
        .nrst_in    (nrst_in),
        .wr_lo_in   (wr_enable_lo),
        .wr_hi_in   (wr_enable_hi),
        .wdata_in   (host_wdata_in),
        .status_in  (status_reg),
        .enable_out (enable_word),
        .gated_out  (gated_word)
    );

    assign interrupt_enable_out = enable_word;

    // only enabled bits can raise the request
    assign any_gated = |gated_word;

    // request asserted while any enabled bit is set
    always @*
    begin
        irq_next = 1'b0;
        if (any_gated)
        begin
            irq_next = 1'b1;
        end
    end

    // request register, active while any enabled bit set
    always @(posedge clk_sys_in)
    begin
        if (!nrst_in)
        begin
            irq_reg <= 1'b0;
        end
        else
        begin
            irq_reg <= irq_next;
        end
    end

    // request pin is active low
    assign irq_n_out = ~irq_reg;

    // byte read decode; unmapped addresses read zero
    always @*
    begin
        rdata_next = `RDATA_RESET;
        // status and enable words at their byte addresses
        if (hit_status_lo)
        begin
            rdata_next = byte_sel(status_reg, 1'b0);
        end
        else if (hit_status_hi)
        begin
            rdata_next = byte_sel(status_reg, 1'b1);
        end
        else if (hit_enable_lo)
        begin
            rdata_next = byte_sel(enable_word, 1'b0);
        end
        else if (hit_enable_hi)
        begin
            rdata_next = byte_sel(enable_word, 1'b1);
        end
        else
        begin
            rdata_next = `RDATA_RESET;
        end
    end

    // valid pulse one cycle after the read strobe
    always @(posedge clk_sys_in)
    begin
        if (!nrst_in)
        begin
            host_rvalid_out <= 1'b0;
        end
        else
        begin
            host_rvalid_out <= host_rd_in;
        end
    end

    // read byte captured with the strobe, held until the next read
    always @(posedge clk_sys_in)
    begin
        if (!nrst_in)
        begin
            host_rdata_out <= `RDATA_RESET;
        end
        else if (host_rd_in)
        begin
            host_rdata_out <= rdata_next;
        end
    end

endmodule // interrupt_summary_status

/* File: verification/host_model.sv */
// host model issuing byte reads and writes on the register port
`timescale 1ns/1ps
module host_model
(
    input  wire       clk_sys_in,
    output reg  [9:0] addr_out,
    output reg        wr_out,
    output reg        rd_out,
    output reg  [7:0] wdata_out,
    input  wire [7:0] rdata_in,
    input  wire       rvalid_in,
    input  wire       wr_pass_in
);
    // idle port at time zero
    initial
    begin
        addr_out = 10'h000;
        wr_out = 1'b0;
        rd_out = 1'b0;
        wdata_out = 8'h00;
    end

    // one read strobe; byte taken with the valid pulse a cycle later
    task rd_byte(input [9:0] a, output [7:0] d, output v);
        begin
            @(posedge clk_sys_in);
            addr_out <= a;
            rd_out <= 1'b1;
            @(posedge clk_sys_in);
            rd_out <= 1'b0;
            #1;
            v = rvalid_in;
            d = rdata_in;
        end
    endtask

    // one write strobe; pass flag seen while the strobe stands
    task wr_byte(input [9:0] a, input [7:0] d, output p);
        begin
            @(posedge clk_sys_in);
            addr_out <= a;
            wdata_out <= d;
            wr_out <= 1'b1;
            #1;
            p = wr_pass_in;
            @(posedge clk_sys_in);
            wr_out <= 1'b0;
            wdata_out <= ~d; // released data never shows the last byte
        end
    endtask
endmodule // host_model

/* File: verification/irq_summary_props.sv */
// checker for the interrupt summary status block ports
`timescale 1ns/1ps
`include "irq_summary_defines.vh"
module irq_summary_props
#(
    parameter VBUS_W = 8
)
(
    input wire              clk_sys_in,
    input wire              nrst_in,
    input wire              timer_underflow_flag_in,
    input wire              config_done_in,
    input wire              power_irq_pending_in,
    input wire [VBUS_W-1:0] bus_voltage_change_in,
    input wire [9:0]        host_addr_in,
    input wire              host_wr_in,
    input wire              host_rd_in,
    input wire [7:0]        host_wdata_in,
    input wire              host_wr_pass_out,
    input wire              host_rvalid_out,
    input wire              configured_flag_out,
    input wire [15:0]       interrupt_summary_status_out,
    input wire [15:0]       interrupt_enable_out,
    input wire              irq_n_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);

    timer_follow_a: assert property ($past(nrst_in) |->
        interrupt_summary_status_out[14] == $past(timer_underflow_flag_in))
        else $error("timer bit does not follow flag");
    vbus_follow_a: assert property ($past(nrst_in) |->
        interrupt_summary_status_out[9] == |$past(bus_voltage_change_in))
        else $error("bus voltage bit wrong");
    power_event_a: assert property ($rose(power_irq_pending_in) |=>
        interrupt_summary_status_out[10]) else $error("power bit late");
    reserved_zero_a: assert property (
        (interrupt_summary_status_out & 16'hA800) == 16'h0000)
        else $error("reserved status bit set");
    irq_request_a: assert property ($past(nrst_in) |->
        irq_n_out == !(|($past(interrupt_summary_status_out)
        & $past(interrupt_enable_out)))) else $error("irq wrong");
    ready_chain_a: assert property (config_done_in |-> ##2
        interrupt_summary_status_out[12]) else $error("ready bit late");
    ready_mirror_a: assert property (configured_flag_out |=>
        interrupt_summary_status_out[12]) else $error("ready not mirrored");
    write_lock_a: assert property (interrupt_summary_status_out[6]
        && host_wr_in && host_addr_in != `WDT_CTRL_ADDR
        |-> !host_wr_pass_out) else $error("write passed under lock");
    wdog_clear_a: assert property (host_wr_in
        && host_addr_in == `WDT_CTRL_ADDR |-> host_wr_pass_out)
        else $error("watchdog clear blocked");
    read_answer_a: assert property (host_rd_in |=>
        host_rvalid_out) else $error("no read valid");
    enable_write_a: assert property (host_wr_in
        && !interrupt_summary_status_out[6]
        && host_addr_in == `ENABLE_LO_ADDR |=>
        interrupt_enable_out[7:0] == $past(host_wdata_in))
        else $error("enable low byte not written");
    enable_hold_a: assert property (host_wr_in
        && interrupt_summary_status_out[6] |=>
        $stable(interrupt_enable_out)) else $error("enable changed");
endmodule // irq_summary_props

bind interrupt_summary_status irq_summary_props #(.VBUS_W(VBUS_W)) u_props
(
    .clk_sys_in                   (clk_sys_in),
    .nrst_in                      (nrst_in),
    .timer_underflow_flag_in      (timer_underflow_flag_in),
    .config_done_in               (config_done_in),
    .power_irq_pending_in         (power_irq_pending_in),
    .bus_voltage_change_in        (bus_voltage_change_in),
    .host_addr_in                 (host_addr_in),
    .host_wr_in                   (host_wr_in),
    .host_rd_in                   (host_rd_in),
    .host_wdata_in                (host_wdata_in),
    .host_wr_pass_out             (host_wr_pass_out),
    .host_rvalid_out              (host_rvalid_out),
    .configured_flag_out          (configured_flag_out),
    .interrupt_summary_status_out (interrupt_summary_status_out),
    .interrupt_enable_out         (interrupt_enable_out),
    .irq_n_out                    (irq_n_out)
);

/* File: verification/testbench.sv */
// self-checking bench for the interrupt summary status word
`timescale 1ns/1ps
`include "irq_summary_defines.vh"
module testbench;
    reg         clk_sys_in, nrst_in, timer_underflow_flag_in;
    reg         config_done_in, power_irq_pending_in, hot_plug_pending_in;
    reg         power_switch_pending_in, watchdog_expired_flag_in;
    reg         port_power_pending_in, pd_link_pending_in;
    reg         pin_override_pending_in, cable_detect_pending_in;
    reg  [7:0]  bus_voltage_change_in, overcurrent_change_in;
    reg  [15:0] pin_irq_status_in;
    wire [9:0]  host_addr_in;
    wire        host_wr_in, host_rd_in, host_wr_pass_out, host_rvalid_out;
    wire        configured_flag_out, irq_n_out;
    wire [7:0]  host_wdata_in, host_rdata_out;
    wire [15:0] interrupt_summary_status_out, interrupt_enable_out;
    integer     err_count, check_count, cyc, i;
    reg  [15:0] src, exp_en, e;
    reg         ready, v, p;
    reg  [7:0]  d;

    interrupt_summary_status #(.VBUS_W(8), .OCS_W(8), .PIN_W(16))
        i_interrupt_summary_status (.*);
    host_model host (.clk_sys_in(clk_sys_in), .addr_out(host_addr_in),
        .wr_out(host_wr_in), .rd_out(host_rd_in), .wdata_out(host_wdata_in),
        .rdata_in(host_rdata_out), .rvalid_in(host_rvalid_out),
        .wr_pass_in(host_wr_pass_out));

    // clock at 25 MHz
    initial
    begin
        clk_sys_in = 1'b0;
        forever #20 clk_sys_in = ~clk_sys_in;
    end

    // hang guard: cycle ceiling well above the planned run
    always @(posedge clk_sys_in)
    begin
        cyc = cyc + 1;
        if (cyc == 6000)
        begin
            err_count = err_count + 1;
            conclude;
        end
    end

    task conclude;
        begin
            if (err_count == 0 && check_count > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask

    // compare and report one value
    task chk(input [63:0] nm, input [15:0] ex, input [15:0] got);
        begin
            check_count = check_count + 1;
            if (got !== ex)
            begin
                err_count = err_count + 1;
                $display("MISMATCH %0s exp %h got %h", nm, ex, got);
            end
        end
    endtask

    // expected status word from the source pattern and ready flag
    function [15:0] exp_sts(input [15:0] s, input r);
        exp_sts = (s & 16'h47FF) | {3'h0, r, 12'h000};
    endfunction

    // put sources on the inputs; status one cycle on, request two
    task apply(input [15:0] s);
        begin
            @(posedge clk_sys_in);
            timer_underflow_flag_in <= s[14];
            power_irq_pending_in <= s[10];
            bus_voltage_change_in <= s[9] ? 8'h01 << ($urandom % 8) : 8'h00;
            hot_plug_pending_in <= s[8];
            power_switch_pending_in <= s[7];
            watchdog_expired_flag_in <= s[6];
            port_power_pending_in <= s[5];
            pd_link_pending_in <= s[4];
            overcurrent_change_in <= s[3] ? 8'h80 >> ($urandom % 8) : 8'h00;
            pin_override_pending_in <= s[2];
            pin_irq_status_in <= s[1] ? 16'h1 << ($urandom % 16) : 16'h0;
            cable_detect_pending_in <= s[0];
            e = exp_sts(s, ready);
            @(posedge clk_sys_in);
            #1;
            chk("status", e, interrupt_summary_status_out);
            @(posedge clk_sys_in);
            #1;
            chk("irq_n", ~|(e & exp_en), irq_n_out);
        end
    endtask

    // enable byte write with the expected word kept alongside
    task wr_en(input hi, input [7:0] b);
        begin
            host.wr_byte(hi ? `ENABLE_HI_ADDR : `ENABLE_LO_ADDR, b, p);
            if (hi)
                exp_en[15:8] = b & 8'h57;
            else
                exp_en[7:0] = b;
            #1;
            chk("enable", exp_en, interrupt_enable_out);
        end
    endtask

    // main sequence
    initial
    begin
        {err_count, check_count, cyc, ready} = 0;
        {timer_underflow_flag_in, config_done_in, power_irq_pending_in} = 0;
        {hot_plug_pending_in, power_switch_pending_in} = 0;
        {watchdog_expired_flag_in, port_power_pending_in} = 0;
        {pd_link_pending_in, pin_override_pending_in} = 0;
        {cable_detect_pending_in, bus_voltage_change_in} = 0;
        {overcurrent_change_in, pin_irq_status_in} = 0;
        nrst_in = 1'b0;
        exp_en = 16'h1040;
        i = $urandom(52);
        repeat (5) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        #1;
        chk("en_rst", 16'h1040, interrupt_enable_out);
        chk("sts_rst", 16'h0000, interrupt_summary_status_out);
        apply(16'h0000);
        @(posedge clk_sys_in);
        config_done_in <= 1'b1;
        @(posedge clk_sys_in);
        config_done_in <= 1'b0;
        #1;
        chk("cfg", 16'h1, {15'h0, configured_flag_out});
        ready = 1'b1;
        apply(16'h0000);
        for (i = 0; i < 15; i = i + 1)
            if (16'h47FF & (16'h1 << i))
            begin
                apply(16'h1 << i);
                host.rd_byte(`STATUS_LO_ADDR, d, v);
                chk("rd_lo", {7'h0, 1'b1, e[7:0]}, {7'h0, v, d});
                host.rd_byte(`STATUS_HI_ADDR, d, v);
                chk("rd_hi", {7'h0, 1'b1, e[15:8]}, {7'h0, v, d});
                apply(16'h0000);
            end
        host.wr_byte(`STATUS_LO_ADDR, 8'hFF, p);
        host.wr_byte(`STATUS_HI_ADDR, 8'hFF, p);
        #1;
        chk("ro", e, interrupt_summary_status_out);
        host.rd_byte(10'h3F0, d, v);
        chk("unmap", 16'h0100, {7'h0, v, d});
        wr_en(1'b0, 8'h00);
        wr_en(1'b1, 8'h00);
        apply(16'h47FF);
        apply(16'h0000);
        wr_en(1'b1, 8'hFF);
        apply(16'h0040);
        host.wr_byte(`ENABLE_LO_ADDR, 8'hFF, p);
        #1;
        chk("lock_wr", 16'h0000, {15'h0, p});
        chk("lock_en", exp_en, interrupt_enable_out);
        host.wr_byte(`WDT_CTRL_ADDR, 8'h00, p);
        chk("wdclr", 16'h1, {15'h0, p});
        apply(16'h0000);
        wr_en(1'b0, 8'hA5);
        repeat (60)
        begin
            wr_en($urandom % 2, $urandom % 256);
            src = $urandom & 16'hFFBF;
            apply(src);
        end
        conclude;
    end
endmodule // testbench
